// file: rtl/sacc_map.vh
// Register map, field positions, reset values and timing constants
// for the SAR conversion sequencer. Included by the sequencer rtl module and by the bench.
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SACC_CTRL_ADDR    12'h000
`define SACC_STATUS_ADDR  12'h004
`define SACC_IRQ_STAT     12'h008
`define SACC_IRQ_MASK     12'h00c
`define SACC_RESULT_ADDR  12'h010
`define SACC_CFG_ADDR     12'h014

// ****************************************************************
// Configuration register fields (write only, writable in serial and parallel mode)
// ****************************************************************
`define SACC_CFG_TEN      0
`define SACC_CFG_BIP      1
`define SACC_CFG_FAST     2
`define SACC_CFG_LOWP     3
`define SACC_CFG_RST      4'h0

// ****************************************************************
// Control register fields
// ****************************************************************
`define SACC_CTRL_SOFT    0
`define SACC_CTRL_RST     1'b0

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define SACC_IRQ_DONE     0
`define SACC_IRQ_STALE    1
`define SACC_IRQ_W        2

// ****************************************************************
// Mode codes
// ****************************************************************
`define SACC_MODE_NORMAL  2'h0
`define SACC_MODE_FAST    2'h1
`define SACC_MODE_SCALED  2'h2

// ****************************************************************
// Timing: 10 MHz clock; fast-mode idle limit 1 ms
// ****************************************************************
`define SACC_CLK_HZ       10000000
`define SACC_IDLE_LIMIT_US 1000
`define SACC_IDLE_CYCLES  ((`SACC_IDLE_LIMIT_US * (`SACC_CLK_HZ / 1000000)))
`define SACC_ACQ_CYCLES   4'h2
`define SACC_SETTLE       2'h1

`endif

// file: rtl/sacc_search.v
// Successive approximation register: MSB-first binary search.
// Assumes the comparator output settles within one step enable.
`timescale 1ns/1ps

module sacc_search #(
  parameter WIDTH = 14
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             start,
  input  wire             step,
  input  wire             comp_high,
  // Results
  output reg  [WIDTH-1:0] dac_code,
  output reg  [WIDTH-1:0] trial_bit,
  output wire             done
);

  // ****************************************************************
  // Search registers
  // ****************************************************************
  // trial_bit walks from the MSB down; each set weight is kept or
  // dropped according to the comparator.
  assign done = (trial_bit == {WIDTH{1'b0}});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_code  <= {WIDTH{1'b0}};
      trial_bit <= {WIDTH{1'b0}};
    end
    else if (start)
    begin
      dac_code  <= {1'b1, {(WIDTH-1){1'b0}}};
      trial_bit <= {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (step && !done)
    begin
      // Drop the weight when it overshoots, try the next one down
      dac_code  <= ((comp_high ? dac_code : (dac_code & ~trial_bit))
                   | (trial_bit >> 1));
      trial_bit <= trial_bit >> 1;
    end
  end

endmodule

// file: rtl/sacc_ctrl.v
// Conversion sequencer and mode control of a 14-bit SAR converter.
// Assumes convert_start_n and comparator are synchronous to pclk.
`timescale 1ns/1ps
`include "sacc_map.vh"

// Functional notes
// - Convert only after acquisition completes and convert start goes low.
// - Open ground switches first, then move arrays from inputs to ground.
// - Binary search MSB first over fourteen weighted steps.
// - Form output code, then drop busy.
// - Each result belongs to the sample just taken, no latency.
// - Fast select high, low-power low: fast mode.
// - Both selects equal: normal mode.
// - Fast low, low-power high: scaled mode, power down after conversion.
// - Fast mode calibrates each conversion; flag idle gaps over 1 ms.
// - Range and mode from pins in hardware modes, register in software.
// - New settings take effect after one acquisition, no reset.
// - Mode pins ignored while configuration register is used.
// - Four ranges: 0-5 V, 0-10 V, +-5 V, +-10 V.
// - Serial select high and hardware select low chooses register config.
module sacc_ctrl #(
  parameter WIDTH       = 14,
  parameter IDLE_CYCLES = `SACC_IDLE_CYCLES
) (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Host pins
  input  wire        convert_start_n,
  input  wire        serial_parallel_select,
  input  wire        hardware_software_config_select,
  input  wire        fast_select,
  input  wire        low_power_select,
  input  wire        range_ten,
  input  wire        range_bipolar,
  output reg         busy,
  output reg  [WIDTH-1:0] result,
  output wire        irq,
  // Analog switch controls
  input  wire        comparator,
  output reg         positive_ground_switch,
  output reg         negative_ground_switch,
  output reg         array_to_inputs,
  output reg         reference_ground,
  output wire [WIDTH-1:0] capacitive_weighted_array,
  output reg         power_down,
  output reg  [1:0]  active_mode,
  output reg         active_ten,
  output reg         active_bipolar,
  output reg         calib_enable
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [5:0] ST_ACQ    = 6'h01;
  localparam [5:0] ST_READY  = 6'h02;
  localparam [5:0] ST_OPEN   = 6'h04;
  localparam [5:0] ST_HOLD   = 6'h08;
  localparam [5:0] ST_SEARCH = 6'h10;
  localparam [5:0] ST_DONE   = 6'h20;

  reg  [5:0]  state;
  reg  [3:0]  acq_cnt;
  reg         start_prev;
  reg         ctrl_soft;
  reg  [3:0]  cfg_reg;
  reg  [`SACC_IRQ_W-1:0] irq_stat;
  reg  [`SACC_IRQ_W-1:0] irq_mask;
  reg  [31:0] idle_cnt;
  reg         idle_over;
  reg         stale;
  wire        start_fall;
  wire        sar_start;
  wire        sar_done;
  wire [WIDTH-1:0] sar_code;
  wire        use_reg;
  wire [1:0]  sel_mode;
  wire        sel_ten;
  wire        sel_bip;
  wire        sel_fast;
  wire        sel_lowp;
  wire        wr_en;
  wire        rd_en;
  reg  [`SACC_IRQ_W-1:0] next_irq_stat;

  // ****************************************************************
  // Configuration source and mode decode
  // ****************************************************************
  // Register config either by the pin strap pair or the soft override
  assign use_reg  = (serial_parallel_select && !hardware_software_config_select)
                    || ctrl_soft;
  // Mode pins are don't care while the register is in use
  assign sel_fast = use_reg ? cfg_reg[`SACC_CFG_FAST] : fast_select;
  assign sel_lowp = use_reg ? cfg_reg[`SACC_CFG_LOWP] : low_power_select;
  assign sel_ten  = use_reg ? cfg_reg[`SACC_CFG_TEN] : range_ten;
  assign sel_bip  = use_reg ? cfg_reg[`SACC_CFG_BIP] : range_bipolar;
  assign sel_mode = (sel_fast && !sel_lowp) ? `SACC_MODE_FAST :
                    (!sel_fast && sel_lowp) ? `SACC_MODE_SCALED :
                    `SACC_MODE_NORMAL;

  assign start_fall = start_prev && !convert_start_n;
  assign sar_start  = (state == ST_HOLD);

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                  <= ST_ACQ;
      acq_cnt                <= 4'h0;
      start_prev             <= 1'b1;
      busy                   <= 1'b0;
      result                 <= {WIDTH{1'b0}};
      positive_ground_switch <= 1'b1;
      negative_ground_switch <= 1'b1;
      array_to_inputs        <= 1'b1;
      reference_ground       <= 1'b0;
      power_down             <= 1'b0;
      active_mode            <= `SACC_MODE_NORMAL;
      active_ten             <= 1'b0;
      active_bipolar         <= 1'b0;
      calib_enable           <= 1'b0;
    end
    else
    begin
      start_prev <= convert_start_n;
      case (state)
        ST_ACQ:
        begin
          // Settings latch during acquisition, applied to next sample
          active_mode    <= sel_mode;
          active_ten     <= sel_ten;
          active_bipolar <= sel_bip;
          if (acq_cnt == `SACC_ACQ_CYCLES)
            state <= ST_READY;
          else
            acq_cnt <= acq_cnt + 4'h1;
          if (start_fall)
            busy <= 1'b1;
        end
        ST_READY:
        begin
          // Early start in acquisition is kept via busy
          if (start_fall || busy)
          begin
            busy                   <= 1'b1;
            power_down             <= 1'b0;
            positive_ground_switch <= 1'b0;
            negative_ground_switch <= 1'b0;
            calib_enable           <= (active_mode == `SACC_MODE_FAST);
            state                  <= ST_OPEN;
          end
          else
          begin
            // Acquisition goes on while waiting, so late pin changes still count
            active_mode    <= sel_mode;
            active_ten     <= sel_ten;
            active_bipolar <= sel_bip;
          end
        end
        ST_OPEN:
        begin
          array_to_inputs  <= 1'b0;
          reference_ground <= 1'b1;
          state            <= ST_HOLD;
        end
        ST_HOLD:
          state <= ST_SEARCH;
        ST_SEARCH:
          if (sar_done)
          begin
            result <= sar_code;
            state  <= ST_DONE;
          end
        ST_DONE:
        begin
          busy                   <= 1'b0;
          calib_enable           <= 1'b0;
          power_down             <= (active_mode == `SACC_MODE_SCALED);
          positive_ground_switch <= 1'b1;
          negative_ground_switch <= 1'b1;
          array_to_inputs        <= 1'b1;
          reference_ground       <= 1'b0;
          acq_cnt                <= 4'h0;
          state                  <= ST_ACQ;
        end
        default:
          state <= ST_ACQ;
      endcase
    end
  end

  sacc_search #(
    .WIDTH (WIDTH)
  ) u_search (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (sar_start),
    .step      (state == ST_SEARCH),
    .comp_high (comparator),
    .dac_code  (capacitive_weighted_array),
    .trial_bit (),
    .done      (sar_done)
  );
  // Final code holds after the last step
  assign sar_code = capacitive_weighted_array;

  // ****************************************************************
  // Fast-mode idle watchdog
  // ****************************************************************
  // Calibration drifts if idle too long; the next result is flagged
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cnt  <= 32'h0;
      idle_over <= 1'b0;
      stale     <= 1'b0;
    end
    else if (state == ST_OPEN)
    begin
      idle_cnt  <= 32'h0;
      idle_over <= 1'b0;
      stale     <= idle_over && (active_mode == `SACC_MODE_FAST);
    end
    else if (idle_cnt >= IDLE_CYCLES[31:0])
      idle_over <= 1'b1;
    else
      idle_cnt <= idle_cnt + 32'h1;
  end

  // ****************************************************************
  // APB slave and interrupts
  // ****************************************************************
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign irq     = |(irq_stat & irq_mask);

  always @*
  begin
    next_irq_stat = irq_stat;
    if (wr_en && paddr == `SACC_IRQ_STAT)
      next_irq_stat = next_irq_stat & ~pwdata[`SACC_IRQ_W-1:0];
    // Set wins over a simultaneous clear
    if (state == ST_DONE)
    begin
      next_irq_stat[`SACC_IRQ_DONE]  = 1'b1;
      next_irq_stat[`SACC_IRQ_STALE] = next_irq_stat[`SACC_IRQ_STALE] | stale;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat  <= {`SACC_IRQ_W{1'b0}};
      irq_mask  <= {`SACC_IRQ_W{1'b0}};
      cfg_reg   <= `SACC_CFG_RST;
      ctrl_soft <= `SACC_CTRL_RST;
      prdata    <= 32'h0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      if (wr_en)
      begin
        case (paddr)
          `SACC_CTRL_ADDR: ctrl_soft <= pwdata[`SACC_CTRL_SOFT];
          `SACC_IRQ_MASK:  irq_mask  <= pwdata[`SACC_IRQ_W-1:0];
          `SACC_CFG_ADDR:  cfg_reg   <= pwdata[3:0];
          default:         ctrl_soft <= ctrl_soft;
        endcase
      end
      if (rd_en && !penable)
      begin
        case (paddr)
          `SACC_CTRL_ADDR:   prdata <= {31'h0, ctrl_soft};
          `SACC_STATUS_ADDR: prdata <= {24'h0, power_down, stale, use_reg,
                                        active_bipolar, active_ten,
                                        active_mode, busy};
          `SACC_IRQ_STAT:    prdata <= {30'h0, irq_stat};
          `SACC_IRQ_MASK:    prdata <= {30'h0, irq_mask};
          `SACC_RESULT_ADDR: prdata <= {18'h0, result};
          default:           prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

// file: verification/sacc_ctrl_checker.sv
// Pin checker for the conversion sequencer.
// Bound to sacc_ctrl; sees only its ports.
`timescale 1ns/1ps
module sacc_ctrl_checker #(
  parameter WIDTH = 14
) (
  // Clock and reset
  input wire             pclk,
  input wire             presetn,
  // Sequencing
  input wire             convert_start_n,
  input wire             busy,
  input wire             positive_ground_switch,
  input wire             negative_ground_switch,
  input wire             array_to_inputs,
  input wire             reference_ground,
  input wire [WIDTH-1:0] capacitive_weighted_array,
  // Mode
  input wire             power_down,
  input wire [1:0]       active_mode,
  input wire             calib_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_start: assert property ($fell(convert_start_n) && !busy |=> busy)
    else $error("busy missed a start");
  a_switch_order: assert property ($fell(positive_ground_switch) |->
    array_to_inputs ##1 (!array_to_inputs && reference_ground))
    else $error("switch order broken");
  a_busy_span: assert property ($fell(positive_ground_switch) |->
    ##17 busy ##1 !busy)
    else $error("busy length wrong");
  a_msb_first: assert property ($rose(reference_ground) |=>
    capacitive_weighted_array == {1'b1, {(WIDTH-1){1'b0}}})
    else $error("first trial not msb");
  a_gnd_pair: assert property (positive_ground_switch == negative_ground_switch)
    else $error("ground switches differ");
  a_mode_legal: assert property (active_mode != 2'h3)
    else $error("illegal mode");
  a_calib_fast: assert property (calib_enable |-> active_mode == 2'h1)
    else $error("calibration outside fast mode");
  a_pd_scaled: assert property ($rose(power_down) |-> active_mode == 2'h2 && !busy)
    else $error("power down outside scaled mode");
  a_pd_idle: assert property (power_down |-> !reference_ground)
    else $error("converting while powered down");
  a_acq_first: assert property ($fell(positive_ground_switch) |->
    $past(positive_ground_switch, 4))
    else $error("conversion before acquisition ended");
  a_calib_on: assert property ($rose(reference_ground) && active_mode == 2'h1 |->
    calib_enable)
    else $error("fast conversion without calibration");
  cover property ($fell(busy));
  cover property (calib_enable);
  cover property ($rose(power_down));
endmodule
bind sacc_ctrl sacc_ctrl_checker #(.WIDTH(WIDTH)) i_chk (
  .pclk(pclk), .presetn(presetn), .convert_start_n(convert_start_n), .busy(busy),
  .positive_ground_switch(positive_ground_switch),
  .negative_ground_switch(negative_ground_switch), .array_to_inputs(array_to_inputs),
  .reference_ground(reference_ground), .capacitive_weighted_array(capacitive_weighted_array),
  .power_down(power_down), .active_mode(active_mode), .calib_enable(calib_enable));

// file: verification/sacc_host_model.sv
// Host model: issues convert starts and answers as the comparator.
// Assumes a one-cycle go request from the bench.
`timescale 1ns/1ps
module sacc_host_model (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Bench side
  input  wire        go,
  input  wire [13:0] target,
  output logic       done,
  // Device side
  input  wire        busy,
  input  wire [13:0] cwa,
  output logic       convert_start_n,
  output wire        comparator
);
  // ****************
  // Start handshake
  // ****************
  logic [1:0] st;
  // Trial bit kept while the array code does not exceed the held input
  assign comparator = (cwa <= target);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st <= 2'h0;
      done <= 1'b0;
      convert_start_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      if (st == 2'h0 && go)
      begin
        convert_start_n <= 1'b0;
        st <= 2'h1;
      end
      if (st == 2'h1 && busy)
        st <= 2'h2;
      // No new start edge until busy has dropped
      if (st == 2'h2 && !busy)
      begin
        convert_start_n <= 1'b1;
        done <= 1'b1;
        st <= 2'h0;
      end
    end
endmodule

// file: verification/sacc_ctrl_tb_top.sv
// Bench for the conversion sequencer.
// Drives APB and config pins; the host model runs conversions.
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_ctrl_tb_top;
  // ****************
  // Signals
  // ****************
  logic        pclk, presetn, psel, penable, pwrite, go, done, csn, cmp;
  logic        sps, hws, fsel, lsel, rten, rbip, pready, pslverr, busy, irq;
  logic        pgs, ngs, ati, rg, pd, ten, bip, cal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [13:0] result, cwa, target;
  logic [1:0]  mode;
  int          fails = 0, check_count = 0, cyc = 0;
  sacc_ctrl #(.WIDTH(14), .IDLE_CYCLES(50)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .convert_start_n(csn),
    .serial_parallel_select(sps), .hardware_software_config_select(hws),
    .fast_select(fsel), .low_power_select(lsel), .range_ten(rten), .range_bipolar(rbip),
    .busy(busy), .result(result), .irq(irq), .comparator(cmp),
    .positive_ground_switch(pgs), .negative_ground_switch(ngs), .array_to_inputs(ati),
    .reference_ground(rg), .capacitive_weighted_array(cwa), .power_down(pd),
    .active_mode(mode), .active_ten(ten), .active_bipolar(bip), .calib_enable(cal));
  sacc_host_model i_host (.pclk(pclk), .presetn(presetn), .go(go), .target(target),
    .done(done), .busy(busy), .cwa(cwa), .convert_start_n(csn), .comparator(cmp));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop;
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task conv(input logic [13:0] t);
    int n;
    repeat (4) @(posedge pclk);
    target <= t;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk("done", 1, done);
    chk("result", {18'h0, t}, {18'h0, result});
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_regs;
    apb(1'b1, 12'h020, 32'hffffffff);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 0, q);
    chk("slave error", 0, {31'h0, pslverr});
    apb(1'b0, `SACC_IRQ_MASK, 32'h0);
    chk("mask reset", 0, q);
  endtask
  task t_modes;
    logic [13:0] tv [4] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1aaa};
    for (int i = 0; i < 4; i++)
    begin
      fsel <= i[0];
      lsel <= i[1];
      rten <= i[0];
      rbip <= i[1];
      conv(tv[i]);
      chk("mode", (i == 1) ? 1 : (i == 2) ? 2 : 0, {30'h0, mode});
      chk("range", i, {30'h0, bip, ten});
      chk("power down", (i == 2), {31'h0, pd});
    end
  endtask
  task t_irq;
    chk("irq masked", 0, {31'h0, irq});
    apb(1'b1, `SACC_IRQ_MASK, 32'h3);
    chk("irq pending", 1, {31'h0, irq});
    apb(1'b1, `SACC_IRQ_STAT, 32'h3);
    apb(1'b1, `SACC_IRQ_MASK, 32'h0);
    chk("irq cleared", 0, {31'h0, irq});
  endtask
  task t_soft;
    apb(1'b1, `SACC_CFG_ADDR, 32'h6);
    apb(1'b0, `SACC_CFG_ADDR, 32'h0);
    chk("cfg reads zero", 0, q);
    sps <= 1'b1;
    fsel <= 1'b0;
    lsel <= 1'b1;
    rten <= 1'b1;
    rbip <= 1'b0;
    conv(14'h0f0f);
    chk("reg mode", 1, {30'h0, mode});
    chk("reg range", 2, {30'h0, bip, ten});
    sps <= 1'b0;
    conv(14'h30c3);
    chk("pin mode", 2, {30'h0, mode});
    apb(1'b1, `SACC_CTRL_ADDR, 32'h1);
    conv(14'h0a5a);
    chk("soft mode", 1, {30'h0, mode});
    chk("soft range", 2, {30'h0, bip, ten});
    apb(1'b1, `SACC_CTRL_ADDR, 32'h0);
    sps <= 1'b1;
    hws <= 1'b1;
    conv(14'h1234);
    chk("strap pins", 2, {30'h0, mode});
    sps <= 1'b0;
    hws <= 1'b0;
  endtask
  task t_stale;
    fsel <= 1'b1;
    lsel <= 1'b0;
    conv(14'h0123);
    repeat (60) @(posedge pclk);
    conv(14'h0456);
    apb(1'b0, `SACC_IRQ_STAT, 32'h0);
    chk("stale set", 1, {31'h0, q[1]});
    apb(1'b1, `SACC_IRQ_STAT, 32'h3);
    conv(14'h0789);
    apb(1'b0, `SACC_IRQ_STAT, 32'h0);
    chk("stale clear", 0, {31'h0, q[1]});
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, go, sps, hws, fsel, lsel, rten, rbip} = '0;
    paddr = '0;
    pwdata = '0;
    target = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_modes;
    t_irq;
    t_soft;
    t_stale;
    report_and_stop;
  end
endmodule
